// ### hdl/acc_top.sv
// Analog comparator control: registers, input select, events, interrupts
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Result bit reads one while positive input exceeds negative input.
// - Mux enabled and converter off: low channel bits pick channels 0 to 7.
// - Mux disabled or converter on: negative pin feeds negative input.
// - Converter control B: mux enable bit 6, trigger field 2:0, rest zero.
// - Disable bit 7 switches comparator power off; zero restores it.
// - Bandgap bit 6 selects bandgap as positive input, else positive pin.
// - Result bit 5 passes a synchroniser, one to two cycles latency.
// - Flag bit 4 set when synced result produces the selected event.
// - Flag cleared by vector execution or writing one; zero leaves it.
// - Request only while flag, enable bit 3 and global enable are set.
// - Capture bit 2 routes result to timer capture; otherwise none.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Pin buffer disable bits 1:0 turn buffers off; port bits read zero.
module acc_top #(
  parameter int unsigned ADDR_W = acc_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire acc_pkg::acc_raw_s raw_in,
  input wire logic converter_enable,
  input wire logic [2:0] channel_select_low,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output acc_pkg::acc_analog_s analog_ctrl,
  output logic pos_pin_buffer_en_n,
  output logic neg_pin_buffer_en_n,
  output logic pos_pin_read,
  output logic neg_pin_read,
  output logic capture_route_enable,
  output logic capture_input,
  output logic [2:0] trigger_select,
  output logic comparator_irq_req,
  output logic irq
);

  if (ADDR_W < acc_pkg::IDX_W + 2) begin : g_chk
    $error("acc_top: ADDR_W too small for the register map");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [6:0] idx);
    hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // Bus handshake: one wait state per access
  logic ack_q;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go = avs_write & ack_q & avs_byteenable[0];
  assign rd_go = avs_read & ~ack_q;
  assign wbyte = avs_writedata[7:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  logic wr_ctrl;
  logic wr_conv;
  logic wr_pin;
  logic wr_iclr;
  logic wr_ien;

  assign wr_ctrl = wr_go & hit(avs_address, acc_pkg::IDX_CMP_CTRL);
  assign wr_conv = wr_go & hit(avs_address, acc_pkg::IDX_CONV_B);
  assign wr_pin = wr_go & hit(avs_address, acc_pkg::IDX_PIN_BUF);
  assign wr_iclr = wr_go & hit(avs_address, acc_pkg::IDX_IRQ_CLR);
  assign wr_ien = wr_go & hit(avs_address, acc_pkg::IDX_IRQ_EN);

  // Synchronised pin and comparator levels
  acc_pkg::acc_raw_s raw_sync;

  acc_sync #(
    .WIDTH($bits(acc_pkg::acc_raw_s))
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(raw_in),
    .sync_out(raw_sync)
  );

  logic result;

  assign result = raw_sync.result;

  // Comparator control fields
  logic disable_q;
  logic bandgap_q;
  logic irq_en_q;
  logic capture_q;
  logic [1:0] mode_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disable_q <= acc_pkg::RST_CMP_CTRL[acc_pkg::B_DISABLE];
      bandgap_q <= acc_pkg::RST_CMP_CTRL[acc_pkg::B_BANDGAP];
      irq_en_q <= acc_pkg::RST_CMP_CTRL[acc_pkg::B_IRQ_EN];
      capture_q <= acc_pkg::RST_CMP_CTRL[acc_pkg::B_CAPTURE];
      mode_q <= acc_pkg::RST_CMP_CTRL[acc_pkg::B_MODE_HI:acc_pkg::B_MODE_LO];
    end else if (wr_ctrl) begin
      disable_q <= wbyte[acc_pkg::B_DISABLE];
      bandgap_q <= wbyte[acc_pkg::B_BANDGAP];
      irq_en_q <= wbyte[acc_pkg::B_IRQ_EN];
      capture_q <= wbyte[acc_pkg::B_CAPTURE];
      mode_q <= wbyte[acc_pkg::B_MODE_HI:acc_pkg::B_MODE_LO];
    end
  end

  // Converter control B fields
  logic mux_en_q;
  logic [2:0] trig_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_en_q <= acc_pkg::RST_CONV_B[acc_pkg::B_MUX_EN];
      trig_q <= acc_pkg::RST_CONV_B[acc_pkg::B_TRIG_HI:acc_pkg::B_TRIG_LO];
    end else if (wr_conv) begin
      mux_en_q <= wbyte[acc_pkg::B_MUX_EN];
      trig_q <= wbyte[acc_pkg::B_TRIG_HI:acc_pkg::B_TRIG_LO];
    end
  end

  // Pin buffer disable
  logic pos_off_q;
  logic neg_off_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_off_q <= acc_pkg::RST_PIN_BUF[acc_pkg::B_POS_OFF];
      neg_off_q <= acc_pkg::RST_PIN_BUF[acc_pkg::B_NEG_OFF];
    end else if (wr_pin) begin
      pos_off_q <= wbyte[acc_pkg::B_POS_OFF];
      neg_off_q <= wbyte[acc_pkg::B_NEG_OFF];
    end
  end

  assign pos_pin_buffer_en_n = pos_off_q;
  assign neg_pin_buffer_en_n = neg_off_q;

  // Port readback forced low while the buffer is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_pin_read <= 1'b0;
      neg_pin_read <= 1'b0;
    end else begin
      pos_pin_read <= raw_sync.pos_pin & ~pos_off_q;
      neg_pin_read <= raw_sync.neg_pin & ~neg_off_q;
    end
  end

  // Analog input selection
  logic use_mux;

  assign use_mux = mux_en_q & ~converter_enable;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.power_off <= disable_q;
      analog_ctrl.bandgap_sel <= bandgap_q;
      analog_ctrl.neg_from_mux <= use_mux;
      analog_ctrl.channel <= use_mux ? channel_select_low : 3'h0;
    end
  end

  // Timer capture routing
  assign capture_route_enable = capture_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_input <= 1'b0;
    end else begin
      capture_input <= capture_q & result;
    end
  end

  assign trigger_select = trig_q;

  // Event detection on the synchronised result
  logic cmp_event;
  logic cmp_toggle;

  acc_edge u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .level(result),
    .mode(acc_pkg::acc_mode_e'(mode_q)),
    .event_p(cmp_event),
    .toggle_p(cmp_toggle)
  );

  // Comparator flag; a new event wins over any clear
  logic flag_q;
  logic flag_clr;

  assign flag_clr = irq_vector_ack | (wr_ctrl & wbyte[acc_pkg::B_FLAG]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= acc_pkg::RST_CMP_CTRL[acc_pkg::B_FLAG];
    end else if (cmp_event) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  assign comparator_irq_req = flag_q & irq_en_q & global_irq_enable;

  // System interrupt status, write-one-to-clear, set wins
  logic [acc_pkg::IRQ_W-1:0] istat_q;
  logic [acc_pkg::IRQ_W-1:0] ien_q;
  logic [acc_pkg::IRQ_W-1:0] iset;

  always_comb begin
    iset = '0;
    iset[acc_pkg::I_EVENT] = cmp_event;
    iset[acc_pkg::I_TOGGLE] = cmp_toggle;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_q <= acc_pkg::RST_IRQ;
    end else begin
      istat_q <= iset | (istat_q & ~(wr_iclr ? wbyte[acc_pkg::IRQ_W-1:0] : '0));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ien_q <= acc_pkg::RST_IRQ;
    end else if (wr_ien) begin
      ien_q <= wbyte[acc_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(istat_q & ien_q);

  // Read data
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    if (hit(avs_address, acc_pkg::IDX_CMP_CTRL)) begin
      rbyte[acc_pkg::B_DISABLE] = disable_q;
      rbyte[acc_pkg::B_BANDGAP] = bandgap_q;
      rbyte[acc_pkg::B_RESULT] = result;
      rbyte[acc_pkg::B_FLAG] = flag_q;
      rbyte[acc_pkg::B_IRQ_EN] = irq_en_q;
      rbyte[acc_pkg::B_CAPTURE] = capture_q;
      rbyte[acc_pkg::B_MODE_HI:acc_pkg::B_MODE_LO] = mode_q;
    end else if (hit(avs_address, acc_pkg::IDX_CONV_B)) begin
      rbyte[acc_pkg::B_MUX_EN] = mux_en_q;
      rbyte[acc_pkg::B_TRIG_HI:acc_pkg::B_TRIG_LO] = trig_q;
    end else if (hit(avs_address, acc_pkg::IDX_PIN_BUF)) begin
      rbyte[acc_pkg::B_POS_OFF] = pos_off_q;
      rbyte[acc_pkg::B_NEG_OFF] = neg_off_q;
    end else if (hit(avs_address, acc_pkg::IDX_IRQ_STAT)) begin
      rbyte[acc_pkg::IRQ_W-1:0] = istat_q;
    end else if (hit(avs_address, acc_pkg::IDX_IRQ_EN)) begin
      rbyte[acc_pkg::IRQ_W-1:0] = ien_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= {24'h00_0000, rbyte};
    end
  end

endmodule

// ### hdl/acc_pkg.sv
// Constants and types for the analog comparator control block
package acc_pkg;

  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned IDX_W = 7;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_CMP_CTRL = 7'h50;
  localparam logic [6:0] IDX_CONV_B = 7'h7b;
  localparam logic [6:0] IDX_PIN_BUF = 7'h7e;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h60;
  localparam logic [6:0] IDX_IRQ_CLR = 7'h61;
  localparam logic [6:0] IDX_IRQ_EN = 7'h62;

  // Comparator control and status fields
  localparam int unsigned B_DISABLE = 7;
  localparam int unsigned B_BANDGAP = 6;
  localparam int unsigned B_RESULT = 5;
  localparam int unsigned B_FLAG = 4;
  localparam int unsigned B_IRQ_EN = 3;
  localparam int unsigned B_CAPTURE = 2;
  localparam int unsigned B_MODE_HI = 1;
  localparam int unsigned B_MODE_LO = 0;

  // Converter control B fields
  localparam int unsigned B_MUX_EN = 6;
  localparam int unsigned B_TRIG_HI = 2;
  localparam int unsigned B_TRIG_LO = 0;

  // Pin buffer disable fields
  localparam int unsigned B_NEG_OFF = 1;
  localparam int unsigned B_POS_OFF = 0;

  // Interrupt status fields
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned I_EVENT = 0;
  localparam int unsigned I_TOGGLE = 1;

  localparam logic [7:0] RST_CMP_CTRL = 8'h00;
  localparam logic [7:0] RST_CONV_B = 8'h00;
  localparam logic [7:0] RST_PIN_BUF = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // Synchroniser depth; result latency of one to two cycles
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RSVD = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_e;

  typedef struct packed {
    logic power_off;
    logic bandgap_sel;
    logic neg_from_mux;
    logic [2:0] channel;
  } acc_analog_s;

  typedef struct packed {
    logic pos_pin;
    logic neg_pin;
    logic result;
  } acc_raw_s;

endpackage

// ### hdl/acc_sync.sv
// Two flip-flop level synchroniser for asynchronous inputs
`timescale 1ns/1ps
module acc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_chk
    $error("acc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### hdl/acc_edge.sv
// Edge detector selecting toggle, falling or rising events
`timescale 1ns/1ps
module acc_edge (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic level,
  input wire acc_pkg::acc_mode_e mode,
  output logic event_p,
  output logic toggle_p
);

  logic prev_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign toggle_p = level ^ prev_q;

  always_comb begin
    unique case (mode)
      acc_pkg::ACC_MODE_TOGGLE: event_p = toggle_p;
      acc_pkg::ACC_MODE_RSVD: event_p = 1'b0;
      acc_pkg::ACC_MODE_FALL: event_p = prev_q & ~level;
      acc_pkg::ACC_MODE_RISE: event_p = ~prev_q & level;
    endcase
  end

endmodule

// ### tb/acc_analog_model.sv
// Behavioural comparator core feeding the raw comparator levels
`timescale 1ns/1ps
module acc_analog_model #(
  parameter int BG_MV = 1100
) (
  input wire acc_pkg::acc_analog_s ctrl,
  input wire logic [15:0] pos_mv,
  input wire logic [15:0] neg_mv,
  output acc_pkg::acc_raw_s raw
);
  int p;
  int n;
  always_comb begin
    p = ctrl.bandgap_sel ? BG_MV : int'(pos_mv);
    n = ctrl.neg_from_mux ? 100 * int'(ctrl.channel) : int'(neg_mv);
    raw.pos_pin = pos_mv > 16'h3e8;
    raw.neg_pin = neg_mv > 16'h3e8;
    raw.result = !ctrl.power_off && p > n;
  end
endmodule

// ### tb/acc_top_assertions.sv
// Port level checks for the comparator control block
`timescale 1ns/1ps
module acc_top_assertions #(
  parameter int unsigned ADDR_W = 9
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire acc_pkg::acc_raw_s raw_in,
  input wire logic converter_enable,
  input wire logic [2:0] channel_select_low,
  input wire logic global_irq_enable,
  input wire acc_pkg::acc_analog_s analog_ctrl,
  input wire logic pos_pin_buffer_en_n,
  input wire logic pos_pin_read,
  input wire logic capture_route_enable,
  input wire logic capture_input,
  input wire logic comparator_irq_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_conv_on;
    $past(converter_enable) |-> !analog_ctrl.neg_from_mux;
  endproperty
  a_conv_on: assert property (p_conv_on) else $error("mux used with converter on");
  property p_chan;
    analog_ctrl.neg_from_mux |-> analog_ctrl.channel == $past(channel_select_low);
  endproperty
  a_chan: assert property (p_chan) else $error("channel differs");
  property p_buf_off;
    pos_pin_buffer_en_n |=> !pos_pin_read;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("pin read with buffer off");
  property p_ctrl_wr;
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[8:2] == acc_pkg::IDX_CMP_CTRL
      |-> ##2 {analog_ctrl.power_off, analog_ctrl.bandgap_sel} == $past(avs_writedata[7:6], 2);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("power or bandgap not applied");
  property p_convb_rd;
    avs_read && !avs_waitrequest && avs_address[8:2] == acc_pkg::IDX_CONV_B
      |-> avs_readdata[31:7] == 25'h0 && avs_readdata[5:3] == 3'h0;
  endproperty
  a_convb_rd: assert property (p_convb_rd) else $error("reserved bits not zero");
  property p_gie;
    !global_irq_enable |-> !comparator_irq_req;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_no_route;
    !$past(capture_route_enable) |-> !capture_input;
  endproperty
  a_no_route: assert property (p_no_route) else $error("capture without route");
  property p_sync;
    (capture_route_enable && $rose(raw_in.result)) ##1 (capture_route_enable && raw_in.result)[*2]
      |=> capture_input;
  endproperty
  a_sync: assert property (p_sync) else $error("result latency wrong");
endmodule

// ### tb/test_analog_comparator_control.sv
// Register level tests of the comparator control block
`timescale 1ns/1ps
module test_analog_comparator_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [8:0] avs_address = 9'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic avs_waitrequest;
  acc_pkg::acc_raw_s raw_in;
  acc_pkg::acc_analog_s analog_ctrl;
  logic converter_enable = 1'b0;
  logic [2:0] channel_select_low = 3'h0;
  logic global_irq_enable = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic [15:0] pos_mv = 16'h0;
  logic [15:0] neg_mv = 16'h64;
  logic pos_pin_buffer_en_n, neg_pin_buffer_en_n, pos_pin_read, neg_pin_read;
  logic capture_route_enable, capture_input, comparator_irq_req, irq;
  logic [2:0] trigger_select;
  int mismatches = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  acc_top dut (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .raw_in, .converter_enable,
    .channel_select_low, .global_irq_enable, .irq_vector_ack, .analog_ctrl,
    .pos_pin_buffer_en_n, .neg_pin_buffer_en_n, .pos_pin_read, .neg_pin_read,
    .capture_route_enable, .capture_input, .trigger_select, .comparator_irq_req, .irq);
  acc_analog_model model (.ctrl(analog_ctrl), .pos_mv(pos_mv), .neg_mv(neg_mv), .raw(raw_in));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        mismatches++;
        give_verdict();
      end
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(0, acc_pkg::IDX_CMP_CTRL, 8'h0);
    chk("ctrl", q, 32'h0);
    bus(1, acc_pkg::IDX_CONV_B, 8'hff);
    bus(0, acc_pkg::IDX_CONV_B, 8'h0);
    chk("conv_b", q, 32'h47);
    chk("trigger", 32'(trigger_select), 32'h7);
    avs_byteenable <= 4'h0;
    bus(1, acc_pkg::IDX_CONV_B, 8'h00);
    avs_byteenable <= 4'h1;
    bus(0, acc_pkg::IDX_CONV_B, 8'h0);
    chk("conv_b no lane", q, 32'h47);
    bus(0, 7'h0, 8'h0);
    chk("unmapped", q, 32'h0);
    pos_mv <= 16'h190;
    for (int ch = 0; ch < 8; ch++) begin
      channel_select_low <= 3'(ch);
      repeat (5) @(posedge clk);
      bus(0, acc_pkg::IDX_CMP_CTRL, 8'h0);
      chk("mux result", 32'(q[5]), 32'(400 > 100 * ch));
    end
    converter_enable <= 1'b1;
    repeat (5) @(posedge clk);
    bus(0, acc_pkg::IDX_CMP_CTRL, 8'h0);
    chk("pin result", 32'(q[5]), 32'h1);
    neg_mv <= 16'h1f4;
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h40);
    repeat (4) @(posedge clk);
    bus(0, acc_pkg::IDX_CMP_CTRL, 8'h0);
    chk("bandgap result", 32'(q[5]), 32'h1);
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h80);
    repeat (4) @(posedge clk);
    chk("power off", 32'(analog_ctrl.power_off), 32'h1);
    for (int m = 0; m < 4; m++) begin
      bus(1, acc_pkg::IDX_CMP_CTRL, {4'h1, 2'h0, 2'(m)});
      pos_mv <= 16'h258;
      repeat (5) @(posedge clk);
      bus(0, acc_pkg::IDX_CMP_CTRL, 8'h0);
      chk("rise flag", 32'(q[4]), 32'(m == 0 || m == 3));
      bus(1, acc_pkg::IDX_CMP_CTRL, {4'h1, 2'h0, 2'(m)});
      pos_mv <= 16'h0;
      repeat (5) @(posedge clk);
      bus(0, acc_pkg::IDX_CMP_CTRL, 8'h0);
      chk("fall flag", 32'(q[4]), 32'(m == 0 || m == 2));
    end
    bus(0, acc_pkg::IDX_IRQ_STAT, 8'h0);
    chk("status", q, 32'h3);
    bus(1, acc_pkg::IDX_IRQ_EN, 8'h3);
    chk("irq", 32'(irq), 32'h1);
    bus(1, acc_pkg::IDX_IRQ_CLR, 8'h3);
    chk("irq cleared", 32'(irq), 32'h0);
    bus(0, acc_pkg::IDX_IRQ_CLR, 8'h0);
    chk("clear reads", q, 32'h0);
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h1b);
    pos_mv <= 16'h258;
    repeat (5) @(posedge clk);
    chk("req no gie", 32'(comparator_irq_req), 32'h0);
    global_irq_enable <= 1'b1;
    @(posedge clk);
    chk("req", 32'(comparator_irq_req), 32'h1);
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h0b);
    chk("flag kept", 32'(comparator_irq_req), 32'h1);
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h03);
    chk("req masked", 32'(comparator_irq_req), 32'h0);
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h0b);
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    @(posedge clk);
    chk("flag acked", 32'(comparator_irq_req), 32'h0);
    bus(1, acc_pkg::IDX_PIN_BUF, 8'h03);
    pos_mv <= 16'hbb8;
    neg_mv <= 16'hbb8;
    repeat (4) @(posedge clk);
    chk("pin off", 32'(pos_pin_read), 32'h0);
    chk("neg pin off", 32'(neg_pin_read), 32'h0);
    chk("buffers off", 32'({pos_pin_buffer_en_n, neg_pin_buffer_en_n}), 32'h3);
    bus(0, acc_pkg::IDX_PIN_BUF, 8'h0);
    chk("pin_buf", q, 32'h3);
    bus(1, acc_pkg::IDX_PIN_BUF, 8'h0);
    repeat (4) @(posedge clk);
    chk("pin on", 32'(pos_pin_read), 32'h1);
    chk("neg pin on", 32'(neg_pin_read), 32'h1);
    chk("buffers on", 32'({pos_pin_buffer_en_n, neg_pin_buffer_en_n}), 32'h0);
    pos_mv <= 16'h0;
    neg_mv <= 16'h1f4;
    bus(1, acc_pkg::IDX_CMP_CTRL, 8'h07);
    chk("route", 32'(capture_route_enable), 32'h1);
    repeat (4) @(posedge clk);
    chk("capture low", 32'(capture_input), 32'h0);
    pos_mv <= 16'h258;
    repeat (5) @(posedge clk);
    chk("capture high", 32'(capture_input), 32'h1);
    give_verdict();
  end
endmodule
bind acc_top acc_top_assertions #(.ADDR_W(ADDR_W)) chk_i (.clk, .arst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .raw_in, .converter_enable, .channel_select_low, .global_irq_enable, .analog_ctrl,
  .pos_pin_buffer_en_n, .pos_pin_read, .capture_route_enable, .capture_input,
  .comparator_irq_req);
